/* File: rtl/itr_pkg.sv */
// Package with register map, field layout and types of the integration test registers
`default_nettype none
package itr_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [11:0] ITR_OFF_CONTROL = 12'hF00;
  localparam logic [11:0] ITR_OFF_INPUT_ONE = 12'hF20;
  localparam logic [11:0] ITR_OFF_INPUT_TWO = 12'hF24;
  localparam logic [11:0] ITR_OFF_OUTPUT = 12'hF40;
  localparam logic [11:0] ITR_OFF_SCRATCH = 12'hF60;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int ITR_INPUT_TWO_WIDTH = 12;
  localparam int ITR_OUTPUT_WIDTH = 4;
  localparam logic ITR_RST_MODE = 1'h0;
  localparam logic [31:0] ITR_RST_INPUT_ONE = 32'h0000_0000;
  localparam logic [11:0] ITR_RST_INPUT_TWO = 12'h000;
  localparam logic [3:0] ITR_RST_OUTPUT = 4'h0;
  localparam logic [31:0] ITR_RST_SCRATCH = 32'h0000_0000;
  // Wait states inserted before pready
  localparam logic [0:0] ITR_WAIT_STATES = 1'h1;

  // ==========================================================================
  // Field positions in the first input register
  // ==========================================================================
  localparam int ITR_POS_DDR_POL = 31;
  localparam int ITR_POS_DDR_DLY = 29;
  localparam int ITR_POS_SDR_POL = 28;
  localparam int ITR_POS_SDR_DLY = 26;
  localparam int ITR_POS_CS5_CAS = 22;
  localparam int ITR_POS_CS5_MAP = 13;
  localparam int ITR_POS_CS5_DEV = 10;
  localparam int ITR_POS_CAL_ACK = 9;
  localparam int ITR_POS_CS1_PB = 8;
  localparam int ITR_POS_CS_POL = 4;
  localparam int ITR_POS_CS1_MW = 2;
  localparam int ITR_POS_BIG_END = 1;
  localparam int ITR_POS_SREF = 0;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Inputs mirrored by the first input register, in register bit order
  typedef struct packed {
    logic ddr_pad_polarity_in;
    logic [1:0] ddr_pad_delay_cfg_in;
    logic sdr_pad_polarity_in;
    logic [1:0] sdr_pad_delay_cfg_in;
    logic [3:0] cs5_column_latency_in;
    logic [8:0] cs5_address_mapping_in;
    logic [2:0] cs5_device_type_in;
    logic delay_line_cal_ack_in;
    logic cs1_byte_lane_polarity_in;
    logic [3:0] chip_select_polarity_in;
    logic [1:0] cs1_memory_width_in;
    logic big_endian_select_in;
    logic self_refresh_request_in;
  } itr_inputs_one_type;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } itr_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } itr_apb_rsp_type;

  // Register decode result
  typedef enum logic [2:0] {
    ITR_SEL_NONE,
    ITR_SEL_CONTROL,
    ITR_SEL_INPUT_ONE,
    ITR_SEL_INPUT_TWO,
    ITR_SEL_OUTPUT,
    ITR_SEL_SCRATCH
  } itr_sel_type;

endpackage
`default_nettype wire

/* File: rtl/itr_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module itr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic power_on_reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
    logic [WIDTH-1:0] stage_three;
    logic [WIDTH-1:0] held;
  } itr_sync_state_type;

  itr_sync_state_type state;
  itr_sync_state_type next_state;

  // Shift chain; held value follows only where stages two and three agree
  always_comb begin
    next_state = state;
    next_state.stage_one = async_in;
    next_state.stage_two = state.stage_one;
    next_state.stage_three = state.stage_two;
    for (int i = 0; i < WIDTH; i++) begin
      if (state.stage_two[i] == state.stage_three[i]) begin
        next_state.held[i] = state.stage_three[i];
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.held;

endmodule
`default_nettype wire

/* File: rtl/itr_test_regs.sv */
// Integration test registers: test mode, input capture, output drive and scratch over APB
//
// Behaviour
// - Control bit 0 at 0xF00 selects test mode
// - Mode bit cleared by either reset
// - First input register 0xF20, power-on reset only
// - Read gives stored value or live input
// - In test mode writes set/clear field bits
// - Second input register 0xF24, 12 bits, power-on reset
// - Output register 0xF40 drives four outputs
// - Scratch register 0xF60 cleared by both resets
// - Every access takes one wait state
// - Control bits 31:1 reserved, read zero
// - Bits 31..29 mirror DDR pad inputs
// - Bits 28..26 mirror SDR pad inputs
// - Bits 25..10 mirror chip select five inputs
// - Bits 9..0 mirror calibration, polarity, memory width, endian, refresh
`timescale 1ns/1ps
`default_nettype none
module itr_test_regs
  import itr_pkg::*;
#(
  parameter int INPUT_TWO_WIDTH = ITR_INPUT_TWO_WIDTH,
  parameter int OUTPUT_WIDTH = ITR_OUTPUT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_n,
  input wire itr_apb_req_type apb_req,
  output itr_apb_rsp_type apb_rsp,
  input wire itr_inputs_one_type inputs_one_pin,
  input wire logic [INPUT_TWO_WIDTH-1:0] inputs_two_pin,
  output itr_inputs_one_type inputs_one_core,
  output logic [INPUT_TWO_WIDTH-1:0] inputs_two_core,
  output logic [OUTPUT_WIDTH-1:0] test_output_drive,
  output logic test_mode
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Map a word address to a register select
  function automatic itr_sel_type itr_decode(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'h0};
    case (word)
      ITR_OFF_CONTROL: itr_decode = ITR_SEL_CONTROL;
      ITR_OFF_INPUT_ONE: itr_decode = ITR_SEL_INPUT_ONE;
      ITR_OFF_INPUT_TWO: itr_decode = ITR_SEL_INPUT_TWO;
      ITR_OFF_OUTPUT: itr_decode = ITR_SEL_OUTPUT;
      ITR_OFF_SCRATCH: itr_decode = ITR_SEL_SCRATCH;
      default: itr_decode = ITR_SEL_NONE;
    endcase
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  // Registers cleared by both resets
  typedef struct packed {
    logic mode;
    logic [31:0] scratch;
    logic waited;
    logic [31:0] rdata;
  } itr_bus_state_type;

  // Registers cleared by the power-on reset only
  typedef struct packed {
    logic [31:0] input_one;
    logic [INPUT_TWO_WIDTH-1:0] input_two;
    logic [OUTPUT_WIDTH-1:0] output_drive;
  } itr_por_state_type;

  itr_bus_state_type state;
  itr_bus_state_type next_state;
  itr_por_state_type por_state;
  itr_por_state_type next_por_state;

  itr_inputs_one_type live_one;
  logic [INPUT_TWO_WIDTH-1:0] live_two;
  logic both_resets_n;
  itr_sel_type sel;
  logic access;
  logic done;
  logic [31:0] view_one;
  logic [31:0] view_two;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Pin inputs come from outside this clock domain
  itr_sync #(
    .WIDTH($bits(itr_inputs_one_type))
  ) u_sync_one (
    .pclk(pclk),
    .power_on_reset_n(power_on_reset_n),
    .async_in(inputs_one_pin),
    .sync_out(live_one)
  );

  itr_sync #(
    .WIDTH(INPUT_TWO_WIDTH)
  ) u_sync_two (
    .pclk(pclk),
    .power_on_reset_n(power_on_reset_n),
    .async_in(inputs_two_pin),
    .sync_out(live_two)
  );

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // Access phase holds one wait cycle, then pready
  always_comb begin
    sel = itr_decode(apb_req.paddr);
    access = apb_req.psel && apb_req.penable;
    done = access && state.waited;
  end

  // Read views: stored fields in test mode, live inputs otherwise
  always_comb begin
    view_one = state.mode ? por_state.input_one : 32'(live_one);
    view_two = '0;
    view_two[INPUT_TWO_WIDTH-1:0] = state.mode ? por_state.input_two : live_two;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Write handling, read data capture and wait tracking
  always_comb begin
    next_state = state;
    next_por_state = por_state;
    next_state.waited = access && !state.waited;
    if (access && !state.waited && !apb_req.pwrite) begin
      case (sel)
        ITR_SEL_CONTROL: next_state.rdata = {31'h0000_0000, state.mode};
        ITR_SEL_INPUT_ONE: next_state.rdata = view_one;
        ITR_SEL_INPUT_TWO: next_state.rdata = view_two;
        ITR_SEL_OUTPUT: next_state.rdata = 32'(por_state.output_drive);
        ITR_SEL_SCRATCH: next_state.rdata = state.scratch;
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    if (done && apb_req.pwrite) begin
      case (sel)
        ITR_SEL_CONTROL: begin
          next_state.mode = apb_req.pwdata[0];
        end
        ITR_SEL_INPUT_ONE: begin
          if (state.mode) begin
            next_por_state.input_one = apb_req.pwdata;
          end
        end
        ITR_SEL_INPUT_TWO: begin
          if (state.mode) begin
            next_por_state.input_two = apb_req.pwdata[INPUT_TWO_WIDTH-1:0];
          end
        end
        ITR_SEL_OUTPUT: begin
          next_por_state.output_drive = apb_req.pwdata[OUTPUT_WIDTH-1:0];
        end
        ITR_SEL_SCRATCH: begin
          next_state.scratch = apb_req.pwdata;
        end
        default: begin
          next_state.scratch = state.scratch;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Either reset clears the bus-side state
  assign both_resets_n = presetn && power_on_reset_n;

  // Mode, scratch and handshake state
  always_ff @(posedge pclk or negedge both_resets_n) begin
    if (!both_resets_n) begin
      state.mode <= ITR_RST_MODE;
      state.scratch <= ITR_RST_SCRATCH;
      state.waited <= 1'b0;
      state.rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
    end
  end

  // Input and output registers survive the bus reset
  always_ff @(posedge pclk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      por_state.input_one <= ITR_RST_INPUT_ONE;
      por_state.input_two <= ITR_RST_INPUT_TWO;
      por_state.output_drive <= ITR_RST_OUTPUT;
    end else begin
      por_state <= next_por_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Bus answer and core-facing multiplexors
  always_comb begin
    apb_rsp.pready = done;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata = state.rdata;
    inputs_one_core = state.mode ? itr_inputs_one_type'(por_state.input_one) : live_one;
    inputs_two_core = state.mode ? por_state.input_two : live_two;
    test_output_drive = por_state.output_drive;
    test_mode = state.mode;
  end

endmodule
`default_nettype wire

/* File: tb/itr_apb_master.sv */
// Bus master model driving test register accesses
`timescale 1ns/1ps
`default_nettype none
module itr_apb_master
  import itr_pkg::*;
(
  input wire logic pclk,
  input wire itr_apb_rsp_type rsp,
  output var itr_apb_req_type req
);
  // Set when a transfer got no answer in time
  logic hung;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  // Setup, access until pready, then release with scrambled data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    hung = (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    req.pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: tb/itr_test_regs_sva.sv */
// Port assertions for the integration test registers
`timescale 1ns/1ps
`default_nettype none
module itr_test_regs_sva
  import itr_pkg::*;
#(
  parameter int INPUT_TWO_WIDTH = 12,
  parameter int OUTPUT_WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_n,
  input wire itr_apb_req_type apb_req,
  input wire itr_apb_rsp_type apb_rsp,
  input wire itr_inputs_one_type inputs_one_pin,
  input wire logic [INPUT_TWO_WIDTH-1:0] inputs_two_pin,
  input wire itr_inputs_one_type inputs_one_core,
  input wire logic [INPUT_TWO_WIDTH-1:0] inputs_two_core,
  input wire logic [OUTPUT_WIDTH-1:0] test_output_drive,
  input wire logic test_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !power_on_reset_n);
  // ==========================================================================
  // Completed transfers
  // ==========================================================================
  logic wr;
  logic rd;
  logic [11:0] a;
  assign a = apb_req.paddr;
  assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  assign rd = apb_req.psel & apb_req.penable & apb_rsp.pready & !apb_req.pwrite;
  chk_one_wait: assert property ($rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("not one wait state");
  chk_idle_ready: assert property (!apb_req.psel |-> !apb_rsp.pready)
    else $error("ready while idle");
  chk_mode_set: assert property (wr && a == ITR_OFF_CONTROL |=> test_mode == $past(apb_req.pwdata[0]))
    else $error("mode not written");
  chk_mode_keep: assert property ($changed(test_mode) |-> $past(wr) && $past(a) == ITR_OFF_CONTROL)
    else $error("mode changed alone");
  chk_mode_reset: assert property ($rose(presetn) |-> !test_mode)
    else $error("mode not cleared");
  chk_out_set: assert property (wr && a == ITR_OFF_OUTPUT |=>
    test_output_drive == $past(apb_req.pwdata[OUTPUT_WIDTH-1:0]))
    else $error("output not driven");
  chk_in_set: assert property (wr && test_mode && a == ITR_OFF_INPUT_ONE |=>
    inputs_one_core == $past(apb_req.pwdata))
    else $error("stored input not seen by core");
  chk_mode_read: assert property (rd && a == ITR_OFF_CONTROL |-> apb_rsp.prdata == {31'h0, test_mode})
    else $error("control read wrong");
  chk_two_read: assert property (rd && test_mode && a == ITR_OFF_INPUT_TWO |->
    apb_rsp.prdata == 32'(inputs_two_core))
    else $error("input two read wrong");
  chk_pin_pass: assert property ((!test_mode && $stable(inputs_one_pin))[*6] |->
    inputs_one_core == inputs_one_pin)
    else $error("core not fed by pins");
  chk_two_pass: assert property ((!test_mode && $stable(inputs_two_pin))[*6] |->
    inputs_two_core == inputs_two_pin)
    else $error("core not fed by second pins");
  chk_no_error: assert property (!apb_rsp.pslverr)
    else $error("error response raised");
  cover property (wr && a == ITR_OFF_CONTROL);
  cover property (wr && test_mode && a == ITR_OFF_INPUT_ONE);
  cover property (rd && !test_mode && a == ITR_OFF_INPUT_ONE);
  cover property (rd && test_mode && a == ITR_OFF_INPUT_TWO);
endmodule
bind itr_test_regs itr_test_regs_sva #(.INPUT_TWO_WIDTH(INPUT_TWO_WIDTH),
  .OUTPUT_WIDTH(OUTPUT_WIDTH)) itr_test_regs_sva_inst (.pclk(pclk), .presetn(presetn),
  .power_on_reset_n(power_on_reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .inputs_one_pin(inputs_one_pin), .inputs_two_pin(inputs_two_pin),
  .inputs_one_core(inputs_one_core), .inputs_two_core(inputs_two_core),
  .test_output_drive(test_output_drive), .test_mode(test_mode));
`default_nettype wire

/* File: tb/tb_itr_test_regs.sv */
// Self-checking bench of the integration test registers
`timescale 1ns/1ps
`default_nettype none
module tb_itr_test_regs
  import itr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic power_on_reset_n = 1'b0;
  itr_apb_req_type req;
  itr_apb_rsp_type rsp;
  itr_inputs_one_type pin1 = '0;
  logic [11:0] pin2 = 12'h000;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] exp_q[$];
  logic [31:0] r1;
  logic [31:0] r2;
  logic [31:0] r3;
  // Clock of 8 ns
  always #4 pclk = ~pclk;
  itr_test_regs itr_test_regs_inst (.pclk(pclk), .presetn(presetn),
    .power_on_reset_n(power_on_reset_n), .apb_req(req), .apb_rsp(rsp),
    .inputs_one_pin(pin1), .inputs_two_pin(pin2), .inputs_one_core(),
    .inputs_two_core(), .test_output_drive(), .test_mode());
  itr_apb_master itr_apb_master_inst (.pclk(pclk), .rsp(rsp), .req(req));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    itr_apb_master_inst.xfer(w, a, d);
    if (itr_apb_master_inst.hung) begin
      n_errors++;
      $display("ERROR %0t no pready", $time);
      results();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic por, input int cyc);
    presetn <= 1'b0;
    if (por) power_on_reset_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    presetn <= 1'b1;
    power_on_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  // Compare each completed read with the oldest expectation
  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      check(rsp.prdata, exp_q.pop_front());
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h4364B7FF));
    pin1 <= itr_inputs_one_type'($urandom);
    pin2 <= 12'($urandom);
    pulse(1'b1, 12);
    rd(ITR_OFF_CONTROL, 32'h0);
    rd(ITR_OFF_OUTPUT, 32'h0);
    rd(ITR_OFF_SCRATCH, 32'h0);
    rd(12'hF80, 32'h0);
    rd(ITR_OFF_INPUT_ONE, pin1);
    rd(ITR_OFF_INPUT_TWO, 32'(pin2));
    acc(1'b1, ITR_OFF_INPUT_ONE, 32'hFFFFFFFF);
    acc(1'b1, ITR_OFF_CONTROL, 32'h1);
    rd(ITR_OFF_CONTROL, 32'h1);
    rd(ITR_OFF_INPUT_ONE, 32'h0);
    r1 = $urandom;
    r2 = $urandom;
    r3 = $urandom;
    acc(1'b1, ITR_OFF_INPUT_ONE, r1);
    acc(1'b1, ITR_OFF_INPUT_TWO, r2);
    acc(1'b1, ITR_OFF_OUTPUT, r3);
    acc(1'b1, ITR_OFF_SCRATCH, ~r1);
    pin1 <= ~pin1;
    pin2 <= ~pin2;
    rd(ITR_OFF_INPUT_ONE, r1);
    rd(ITR_OFF_INPUT_TWO, r2 & 32'hFFF);
    rd(ITR_OFF_OUTPUT, r3 & 32'hF);
    rd(ITR_OFF_SCRATCH, ~r1);
    // Bus reset alone
    pulse(1'b0, 2);
    rd(ITR_OFF_CONTROL, 32'h0);
    rd(ITR_OFF_SCRATCH, 32'h0);
    rd(ITR_OFF_OUTPUT, r3 & 32'hF);
    acc(1'b1, ITR_OFF_CONTROL, 32'h1);
    rd(ITR_OFF_INPUT_ONE, r1);
    rd(ITR_OFF_INPUT_TWO, r2 & 32'hFFF);
    // Power-on reset clears all
    pulse(1'b1, 2);
    acc(1'b1, ITR_OFF_CONTROL, 32'h1);
    rd(ITR_OFF_INPUT_ONE, 32'h0);
    rd(ITR_OFF_INPUT_TWO, 32'h0);
    rd(ITR_OFF_OUTPUT, 32'h0);
    acc(1'b1, ITR_OFF_CONTROL, 32'h0);
    rd(ITR_OFF_INPUT_ONE, pin1);
    rd(ITR_OFF_INPUT_TWO, 32'(pin2));
    results();
  end
endmodule
`default_nettype wire
